// ### logic/adcct_consts.vh
// Register offsets, field positions, reset values and encodings for
// the computation and threshold unit. Included by its design files.
`ifndef ADCCT_CONSTS_VH
`define ADCCT_CONSTS_VH

// ----------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------
`define ADCCT_LTH_L     9'h08C
`define ADCCT_LTH_H     9'h08D
`define ADCCT_UTH_L     9'h08E
`define ADCCT_UTH_H     9'h08F
`define ADCCT_ERR_L     9'h090
`define ADCCT_ERR_H     9'h091
`define ADCCT_SETPOINT_FIELD_L    9'h092
`define ADCCT_SETPOINT_FIELD_H    9'h093
`define ADCCT_FILTER_FIELD_L    9'h094
`define ADCCT_FILTER_FIELD_H    9'h095
`define ADCCT_ACC_L     9'h096
`define ADCCT_ACC_H     9'h097
`define ADCCT_ACC_U     9'h098
`define ADCCT_CNT       9'h099
`define ADCCT_RPT       9'h09A
`define ADCCT_PREV_L    9'h09B
`define ADCCT_PREV_H    9'h09C
`define ADCCT_CTRL      9'h0A0
`define ADCCT_MODE      9'h0A1
`define ADCCT_STAT      9'h0A2

// ----------------------------------------------------------------------
// Control register fields (offset 0x0A0)
// ----------------------------------------------------------------------
`define ADCCT_CTRL_TMD_LSB   0
`define ADCCT_CTRL_ERROR_SELECT_A_LSB  3
`define ADCCT_CTRL_PREVIOUS_SOURCE_SELECT_BIT  6
`define ADCCT_CTRL_GO_BIT    7

// Mode register fields (offset 0x0A1)
`define ADCCT_MODE_MD_LSB    0
`define ADCCT_MODE_CRS_LSB   3

// Status register fields (offset 0x0A2)
`define ADCCT_STAT_BELOW_LOWER_FLAG_BIT  0
`define ADCCT_STAT_ABOVE_UPPER_FLAG_BIT  1
`define ADCCT_STAT_TIF_BIT   2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ADCCT_RST_16    16'h0000
`define ADCCT_RST_8     8'h00

// ----------------------------------------------------------------------
// Threshold modes
// ----------------------------------------------------------------------
`define ADCCT_TMD_NEVER    3'h0
`define ADCCT_TMD_BELOW_L  3'h1
`define ADCCT_TMD_GE_L     3'h2
`define ADCCT_TMD_INSIDE   3'h3
`define ADCCT_TMD_OUTSIDE  3'h4
`define ADCCT_TMD_LE_U     3'h5
`define ADCCT_TMD_ABOVE_U  3'h6
`define ADCCT_TMD_ALWAYS   3'h7

// ----------------------------------------------------------------------
// Computation modes
// ----------------------------------------------------------------------
`define ADCCT_MD_BASIC     3'h0
`define ADCCT_MD_ACCUM     3'h1
`define ADCCT_MD_AVG       3'h2
`define ADCCT_MD_BURST     3'h3
`define ADCCT_MD_LPF       3'h4

// ----------------------------------------------------------------------
// Error calculations
// ----------------------------------------------------------------------
`define ADCCT_ERROR_SELECT_A_DERIV   3'h0
`define ADCCT_ERROR_SELECT_A_SP      3'h1
`define ADCCT_ERROR_SELECT_A_RES_FLT 3'h2
`define ADCCT_ERROR_SELECT_A_FLT_DER 3'h4
`define ADCCT_ERROR_SELECT_A_FLT_SP  3'h5

`endif

// ### logic/adcct_threshold_check.v
// Signed threshold comparator with mode select.
// Assumes operands stable in the cycle the check is taken.
`timescale 1ns/10ps
`include "adcct_consts.vh"

module adcct_threshold_check #(
  parameter WIDTH = 16
) (
  // Operands
  input  wire signed [WIDTH-1:0] errorValue,
  input  wire signed [WIDTH-1:0] lowerThreshold,
  input  wire signed [WIDTH-1:0] upperThreshold,
  // Mode
  input  wire        [2:0]       thresholdModeSelect,
  // Results
  output wire                    belowLower,
  output wire                    aboveUpper,
  output reg                     conditionMet
);

  assign belowLower = errorValue < lowerThreshold;
  assign aboveUpper = errorValue > upperThreshold;

  always @* begin
    case (thresholdModeSelect)
      `ADCCT_TMD_NEVER:   conditionMet = 1'b0;
      `ADCCT_TMD_BELOW_L: conditionMet = belowLower;
      `ADCCT_TMD_GE_L:    conditionMet = !belowLower;
      `ADCCT_TMD_INSIDE:  conditionMet = !belowLower && !aboveUpper;
      `ADCCT_TMD_OUTSIDE: conditionMet = belowLower || aboveUpper;
      `ADCCT_TMD_LE_U:    conditionMet = !aboveUpper;
      `ADCCT_TMD_ABOVE_U: conditionMet = aboveUpper;
      `ADCCT_TMD_ALWAYS:  conditionMet = 1'b1;
      default:            conditionMet = 1'b0;
    endcase
  end

endmodule

// ### logic/adcct_computation_regs.v
// Computation and threshold register unit of a 12-bit converter.
// Assumes results arrive as one-cycle strobes on the system clock and a
// conversion-start strobe from the sequencer on the same clock.
`timescale 1ns/10ps
`include "adcct_consts.vh"

module adcct_computation_regs #(
  parameter ACC_WIDTH = 18,
  parameter CNT_WIDTH = 8
) (
  // Clock and reset
  input  wire        clock,
  input  wire        reset,
  input  wire        powerOnReset,
  // Register port
  input  wire [8:0]  address,
  input  wire [7:0]  writeData,
  input  wire        writeStrobe,
  input  wire        readStrobe,
  output reg  [7:0]  readData,
  // Conversion core
  input  wire        conversionStart,
  input  wire        resultValid,
  input  wire [15:0] resultData,
  // Status and control
  output wire        conversionGo,
  output wire        thresholdInterrupt,
  output wire        aboveUpperFlag,
  output wire        belowLowerFlag
);

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  reg  signed [15:0]          lowerThreshold_q;
  reg  signed [15:0]          upperThreshold_q;
  reg  signed [15:0]          thresholdSetpoint_q;

  reg  signed [15:0]          computedError_q;
  reg  signed [15:0]          filterOutput_q;

  reg  signed [ACC_WIDTH-1:0] accumulator_q;
  reg         [CNT_WIDTH-1:0] repeatCounter_q;
  reg         [7:0]           repeatSetting_q;

  reg         [15:0]          previousResult_q;
  reg         [15:0]          lastResult_q;

  reg         [7:0]           ctrl_q;
  reg         [7:0]           mode_q;

  reg                         aboveUpper_q;
  reg                         belowLower_q;
  reg                         interruptFlag_q;

  wire        [2:0]           thresholdModeSelect;
  wire        [2:0]           errorSelect;
  wire                        previousSourceSelect;
  wire        [2:0]           computeMode;
  wire        [2:0]           rightShiftSelect;

  assign thresholdModeSelect  = ctrl_q[`ADCCT_CTRL_TMD_LSB +: 3];
  assign errorSelect          = ctrl_q[`ADCCT_CTRL_ERROR_SELECT_A_LSB +: 3];
  assign previousSourceSelect = ctrl_q[`ADCCT_CTRL_PREVIOUS_SOURCE_SELECT_BIT];
  assign conversionGo         = ctrl_q[`ADCCT_CTRL_GO_BIT];
  assign computeMode          = mode_q[`ADCCT_MODE_MD_LSB +: 3];
  assign rightShiftSelect     = mode_q[`ADCCT_MODE_CRS_LSB +: 3];

  // --------------------------------------------------------------------
  // Computation datapath
  // --------------------------------------------------------------------
  wire                        repeatMode;
  wire                        lpfMode;

  wire signed [ACC_WIDTH-1:0] resultExt;
  wire signed [ACC_WIDTH-1:0] accumSum;
  wire signed [ACC_WIDTH-1:0] lpfStep;
  wire signed [ACC_WIDTH-1:0] shiftedAcc;
  wire signed [15:0]          newFilter;
  wire        [CNT_WIDTH-1:0] countNext;
  wire                        checkDue;
  wire                        doCheck;

  reg  signed [15:0]          newError;

  assign repeatMode = (computeMode == `ADCCT_MD_AVG)
                   || (computeMode == `ADCCT_MD_BURST)
                   || (computeMode == `ADCCT_MD_LPF);
  assign lpfMode    = computeMode == `ADCCT_MD_LPF;
  assign resultExt  = {{(ACC_WIDTH-16){resultData[15]}}, resultData};
  assign accumSum   = accumulator_q + resultExt;
  // Low-pass step: acc + result - acc >>> shift
  assign lpfStep    = accumSum - (accumulator_q >>> rightShiftSelect);
  assign shiftedAcc = (lpfMode ? lpfStep : accumSum) >>> rightShiftSelect;
  // Filter is shifted accumulator, or filter state in LPF
  assign newFilter  = shiftedAcc[15:0];
  assign countNext  = repeatCounter_q + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
  // Check when count reaches setting; other modes every result
  assign checkDue   = !repeatMode || (countNext >= repeatSetting_q);
  assign doCheck    = resultValid && checkDue;

  always @* begin
    case (errorSelect)
      `ADCCT_ERROR_SELECT_A_DERIV:   newError = $signed(resultData)
                                    - $signed(lastResult_q);
      `ADCCT_ERROR_SELECT_A_SP:      newError = $signed(resultData)
                                    - thresholdSetpoint_q;
      `ADCCT_ERROR_SELECT_A_RES_FLT: newError = $signed(resultData) - newFilter;
      `ADCCT_ERROR_SELECT_A_FLT_DER: newError = newFilter - filterOutput_q;
      `ADCCT_ERROR_SELECT_A_FLT_SP:  newError = newFilter
                                    - thresholdSetpoint_q;
      default:             newError = $signed(resultData)
                                    - $signed(lastResult_q);
    endcase
  end

  // --------------------------------------------------------------------
  // Threshold check
  // --------------------------------------------------------------------
  wire belowLower;
  wire aboveUpper;
  wire conditionMet;

  adcct_threshold_check #(
    .WIDTH               (16)
  ) adcct_threshold_check_i (
    .errorValue          (newError),
    .lowerThreshold      (lowerThreshold_q),
    .upperThreshold      (upperThreshold_q),
    .thresholdModeSelect (thresholdModeSelect),
    .belowLower          (belowLower),
    .aboveUpper          (aboveUpper),
    .conditionMet        (conditionMet)
  );

  assign thresholdInterrupt = interruptFlag_q;
  assign aboveUpperFlag     = aboveUpper_q;
  assign belowLowerFlag     = belowLower_q;

  // --------------------------------------------------------------------
  // Write decode
  // --------------------------------------------------------------------
  wire wrLthL  = writeStrobe && (address == `ADCCT_LTH_L);
  wire wrLthH  = writeStrobe && (address == `ADCCT_LTH_H);

  wire wrUthL  = writeStrobe && (address == `ADCCT_UTH_L);
  wire wrUthH  = writeStrobe && (address == `ADCCT_UTH_H);

  wire wrStptL = writeStrobe && (address == `ADCCT_SETPOINT_FIELD_L);
  wire wrStptH = writeStrobe && (address == `ADCCT_SETPOINT_FIELD_H);

  wire wrAccL  = writeStrobe && (address == `ADCCT_ACC_L)
              && !conversionGo;
  wire wrAccH  = writeStrobe && (address == `ADCCT_ACC_H)
              && !conversionGo;
  wire wrAccU  = writeStrobe && (address == `ADCCT_ACC_U)
              && !conversionGo;

  wire wrCnt   = writeStrobe && (address == `ADCCT_CNT);
  wire wrRpt   = writeStrobe && (address == `ADCCT_RPT);

  wire wrCtrl  = writeStrobe && (address == `ADCCT_CTRL);
  wire wrMode  = writeStrobe && (address == `ADCCT_MODE);
  wire wrStat  = writeStrobe && (address == `ADCCT_STAT);

  // --------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      lowerThreshold_q    <= `ADCCT_RST_16;
      upperThreshold_q    <= `ADCCT_RST_16;
      thresholdSetpoint_q <= `ADCCT_RST_16;
      repeatSetting_q     <= `ADCCT_RST_8;
      ctrl_q              <= `ADCCT_RST_8;
      mode_q              <= `ADCCT_RST_8;
    end else begin
      if (wrLthL) begin
        lowerThreshold_q[7:0] <= writeData;
      end
      if (wrLthH) begin
        lowerThreshold_q[15:8] <= writeData;
      end

      if (wrUthL) begin
        upperThreshold_q[7:0] <= writeData;
      end
      if (wrUthH) begin
        upperThreshold_q[15:8] <= writeData;
      end

      if (wrStptL) begin
        thresholdSetpoint_q[7:0] <= writeData;
      end
      if (wrStptH) begin
        thresholdSetpoint_q[15:8] <= writeData;
      end

      if (wrRpt) begin
        repeatSetting_q <= writeData;
      end
      if (wrCtrl) begin
        ctrl_q <= writeData;
      end
      if (wrMode) begin
        mode_q <= writeData;
      end
    end
  end

  // --------------------------------------------------------------------
  // Status flags; hardware set wins over software clear
  // --------------------------------------------------------------------
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      aboveUpper_q    <= 1'b0;
      belowLower_q    <= 1'b0;
      interruptFlag_q <= 1'b0;
    end else begin
      if (doCheck) begin
        aboveUpper_q <= aboveUpper;
        belowLower_q <= belowLower;
      end
      if (doCheck && conditionMet) begin
        interruptFlag_q <= 1'b1;
      end else if (wrStat && !writeData[`ADCCT_STAT_TIF_BIT]) begin
        interruptFlag_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Computation results; no reset so contents start undefined
  // --------------------------------------------------------------------
  always @(posedge clock) begin
    if (resultValid) begin
      lastResult_q   <= resultData;
      filterOutput_q <= newFilter;
      if (checkDue) begin
        computedError_q <= newError;
      end
    end
    if (conversionStart)
      previousResult_q <= previousSourceSelect
                        ? filterOutput_q : lastResult_q;
    // Accumulator bytes; upper write sets the top bits from low writeData bits
    if (wrAccL) begin
      accumulator_q[7:0] <= writeData;
    end else if (wrAccH) begin
      accumulator_q[15:8] <= writeData;
    end else if (wrAccU) begin
      accumulator_q[ACC_WIDTH-1:16] <= writeData[ACC_WIDTH-17:0];
    end else if (resultValid && (computeMode != `ADCCT_MD_BASIC)) begin
      accumulator_q <= lpfMode ? lpfStep : accumSum;
    end
  end

  // --------------------------------------------------------------------
  // Repeat counter; no reset clears it, power-on reset holds its value
  // --------------------------------------------------------------------
  reg porMeta_q;
  reg porSync_q;

  // Power-on level comes from outside the clock domain
  always @(posedge clock) begin
    porMeta_q <= powerOnReset;
    porSync_q <= porMeta_q;
  end

  always @(posedge clock) begin
    if (porSync_q) begin
      repeatCounter_q <= repeatCounter_q;
    end else if (wrCnt) begin
      repeatCounter_q <= writeData[CNT_WIDTH-1:0];
    end else if (resultValid && repeatMode) begin
      if (checkDue) begin
        repeatCounter_q <= {CNT_WIDTH{1'b0}};
      end else begin
        repeatCounter_q <= countNext;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // --------------------------------------------------------------------
  wire [23:0] accRead;
  assign accRead = {{(24-ACC_WIDTH){accumulator_q[ACC_WIDTH-1]}},
                    accumulator_q};

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      readData <= `ADCCT_RST_8;
    end else if (readStrobe) begin
      case (address)
        `ADCCT_LTH_L:  readData <= lowerThreshold_q[7:0];
        `ADCCT_LTH_H:  readData <= lowerThreshold_q[15:8];
        `ADCCT_UTH_L:  readData <= upperThreshold_q[7:0];
        `ADCCT_UTH_H:  readData <= upperThreshold_q[15:8];
        `ADCCT_ERR_L:  readData <= computedError_q[7:0];
        `ADCCT_ERR_H:  readData <= computedError_q[15:8];
        `ADCCT_SETPOINT_FIELD_L: readData <= thresholdSetpoint_q[7:0];
        `ADCCT_SETPOINT_FIELD_H: readData <= thresholdSetpoint_q[15:8];
        `ADCCT_FILTER_FIELD_L: readData <= filterOutput_q[7:0];
        `ADCCT_FILTER_FIELD_H: readData <= filterOutput_q[15:8];
        `ADCCT_ACC_L:  readData <= accRead[7:0];
        `ADCCT_ACC_H:  readData <= accRead[15:8];
        `ADCCT_ACC_U:  readData <= accRead[23:16];
        `ADCCT_CNT:    readData <= repeatCounter_q;
        `ADCCT_RPT:    readData <= repeatSetting_q;
        `ADCCT_PREV_L: readData <= previousResult_q[7:0];
        `ADCCT_PREV_H: readData <= previousResult_q[15:8];
        `ADCCT_CTRL:   readData <= ctrl_q;
        `ADCCT_MODE:   readData <= mode_q;
        `ADCCT_STAT:   readData <= {5'h00, interruptFlag_q,
                                    aboveUpper_q, belowLower_q};
        default:       readData <= 8'h00;
      endcase
    end else begin
      readData <= 8'h00;
    end
  end

endmodule

// ### verification/adcct_props.sv
// Port checker for the computation and threshold register unit.
// Assumes one clock domain and the offsets of adcct_consts.vh.
`timescale 1ns/10ps
`include "adcct_consts.vh"

module adcct_props (
  // Clock and reset
  input wire       clock,
  input wire       reset,
  // Register port
  input wire [8:0] address,
  input wire [7:0] writeData,
  input wire       writeStrobe,
  input wire       readStrobe,
  input wire [7:0] readData,
  // Conversion core
  input wire       resultValid,
  // Status and control
  input wire       conversionGo,
  input wire       thresholdInterrupt,
  input wire       aboveUpperFlag,
  input wire       belowLowerFlag
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  wire ctrlWrite = writeStrobe && address == `ADCCT_CTRL;
  wire holeRead  = readStrobe && (address < `ADCCT_LTH_L ||
                   address > `ADCCT_STAT ||
                   (address > `ADCCT_PREV_H && address < `ADCCT_CTRL));

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  idle_read_zero_a:
    assert property (!readStrobe |=> readData == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_read_a:
    assert property (holeRead |=> readData == 8'h00)
    else $error("unmapped read returned data");
  acc_sign_ext_a:
    assert property (readStrobe && address == `ADCCT_ACC_U
                     |=> readData[7:2] == {6{readData[1]}})
    else $error("accumulator top byte not sign filled");
  status_view_a:
    assert property (readStrobe && address == `ADCCT_STAT |=>
      readData[2:0] == {$past(thresholdInterrupt),
                        $past(aboveUpperFlag), $past(belowLowerFlag)})
    else $error("status read differs from flags");
  flags_hold_a:
    assert property (!resultValid && !writeStrobe |=>
                     $stable(aboveUpperFlag) && $stable(belowLowerFlag))
    else $error("flags moved without a result");
  irq_cause_a:
    assert property ($rose(thresholdInterrupt) |-> $past(resultValid))
    else $error("interrupt rose without a result");
  irq_sticky_a:
    assert property (thresholdInterrupt && !writeStrobe |=>
                     thresholdInterrupt)
    else $error("interrupt dropped by itself");
  go_write_a:
    assert property (ctrlWrite |=> conversionGo == $past(writeData[7]))
    else $error("go bit not taken from control write");
  go_hold_a:
    assert property (!ctrlWrite |=> $stable(conversionGo))
    else $error("go bit moved without a write");
endmodule

bind adcct_computation_regs adcct_props adcct_props_i (
  .clock(clock), .reset(reset), .address(address),
  .writeData(writeData), .writeStrobe(writeStrobe),
  .readStrobe(readStrobe), .readData(readData),
  .resultValid(resultValid), .conversionGo(conversionGo),
  .thresholdInterrupt(thresholdInterrupt),
  .aboveUpperFlag(aboveUpperFlag), .belowLowerFlag(belowLowerFlag)
);

// ### verification/adcct_core_model.sv
// Behavioural conversion core: start strobe, then a result strobe.
// Assumes one request at a time; delay sets a prompt or slow answer.
`timescale 1ns/10ps

module adcct_core_model (
  // Clock and reset
  input  wire        clock,
  input  wire        reset,
  // Request from the bench
  input  wire        reqStrobe,
  input  wire [15:0] reqValue,
  input  wire [3:0]  reqDelay,
  // Toward the unit
  output reg         conversionStart,
  output reg         resultValid,
  output reg  [15:0] resultData
);
  reg [15:0] value_q;
  reg [3:0]  wait_q;
  reg        busy_q;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      conversionStart <= 1'b0;
      resultValid     <= 1'b0;
      resultData      <= 16'hA5A5;
      value_q         <= 16'h0000;
      wait_q          <= 4'h0;
      busy_q          <= 1'b0;
    end else begin
      conversionStart <= reqStrobe;
      resultValid     <= 1'b0;
      // Data lines toggle outside the result cycle
      resultData      <= ~resultData;
      if (reqStrobe) begin
        busy_q  <= 1'b1;
        value_q <= reqValue;
        wait_q  <= reqDelay;
      end else if (busy_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (busy_q) begin
        busy_q      <= 1'b0;
        resultValid <= 1'b1;
        resultData  <= value_q;
      end
    end
  end
endmodule

// ### verification/adcct_computation_regs_tb_top.sv
// Self-checking bench for the computation and threshold unit.
// Assumes the core model and the bound port checker beside it.
`timescale 1ns/10ps
`include "adcct_consts.vh"
`define CHK(nm, exp, got) begin nChecks++; if ((got) !== (exp)) begin \
  numErrors++; $display("FAIL %s expected %h seen %h", nm, exp, got); \
  end end

module adcct_computation_regs_tb_top;
  reg         clock = 1'b0;
  reg         reset = 1'b1;
  reg         powerOnReset = 1'b1;
  reg  [8:0]  address = 9'h000;
  reg  [7:0]  writeData = 8'h00;
  reg         writeStrobe = 1'b0;
  reg         readStrobe = 1'b0;
  reg         reqStrobe = 1'b0;
  reg  [15:0] reqValue = 16'h0000;
  reg  [3:0]  reqDelay = 4'h0;
  wire [7:0]  readData;
  wire        conversionStart, resultValid, conversionGo;
  wire        thresholdInterrupt, aboveUpperFlag, belowLowerFlag;
  wire [15:0] resultData;
  int         numErrors = 0;
  int         nChecks = 0;
  int         m, k;
  reg  [2:0]  expv;
  reg  [15:0] res [0:4] = '{16'h0050, 16'h005A, 16'h0069, 16'h006E,
                            16'h0082};

  always #10 clock = ~clock;

  adcct_computation_regs adcct_computation_regs_i (
    .clock(clock), .reset(reset), .powerOnReset(powerOnReset),
    .address(address), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .conversionStart(conversionStart),
    .resultValid(resultValid), .resultData(resultData),
    .conversionGo(conversionGo), .thresholdInterrupt(thresholdInterrupt),
    .aboveUpperFlag(aboveUpperFlag), .belowLowerFlag(belowLowerFlag));

  adcct_core_model adcct_core_model_i (
    .clock(clock), .reset(reset), .reqStrobe(reqStrobe),
    .reqValue(reqValue), .reqDelay(reqDelay),
    .conversionStart(conversionStart), .resultValid(resultValid),
    .resultData(resultData));

  // ------------------------------------------------------------------
  // Bus and conversion tasks
  // ------------------------------------------------------------------
  task wr(input [8:0] a, input [7:0] d);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
    @(posedge clock);
  endtask

  task chk_rd(input [8:0] a, input [7:0] e);
    reg [7:0] d;
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 d = readData;
    `CHK("readData", e, d)
    @(posedge clock);
  endtask

  task wr16(input [8:0] a, input [15:0] d);
    wr(a, d[7:0]);
    wr(a + 9'h001, d[15:8]);
  endtask

  task chk16(input [8:0] a, input [15:0] e);
    chk_rd(a, e[7:0]);
    chk_rd(a + 9'h001, e[15:8]);
  endtask

  task convert(input [15:0] v, input [3:0] dly);
    int i;
    reqValue <= v;
    reqDelay <= dly;
    reqStrobe <= 1'b1;
    @(posedge clock);
    reqStrobe <= 1'b0;
    i = 0;
    while (resultValid !== 1'b1 && i < 40) begin
      @(posedge clock);
      i++;
    end
    `CHK("resultValid", 1'b1, resultValid)
    @(posedge clock);
  endtask

  function [2:0] expect_thr(input [2:0] md, input signed [15:0] e, l, u);
    reg hit;
    case (md)
      `ADCCT_TMD_NEVER:   hit = 1'b0;
      `ADCCT_TMD_BELOW_L: hit = e < l;
      `ADCCT_TMD_GE_L:    hit = e >= l;
      `ADCCT_TMD_INSIDE:  hit = e >= l && e <= u;
      `ADCCT_TMD_OUTSIDE: hit = e < l || e > u;
      `ADCCT_TMD_LE_U:    hit = e <= u;
      `ADCCT_TMD_ABOVE_U: hit = e > u;
      default:            hit = 1'b1;
    endcase
    expect_thr = {hit, e > u, e < l};
  endfunction

  task conclude;
    $display("checks %0d errors %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    numErrors++;
    conclude;
  end

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    powerOnReset <= 1'b0;
    @(posedge clock);
    chk16(`ADCCT_LTH_L, 16'h0000);
    chk16(`ADCCT_UTH_L, 16'h0000);
    chk16(`ADCCT_SETPOINT_FIELD_L, 16'h0000);
    chk_rd(`ADCCT_STAT, 8'h00);
    chk_rd(9'h09E, 8'h00);
    wr16(`ADCCT_LTH_L, 16'hFFF6);
    wr16(`ADCCT_UTH_L, 16'h000A);
    wr16(`ADCCT_SETPOINT_FIELD_L, 16'h0064);
    chk16(`ADCCT_LTH_L, 16'hFFF6);
    chk16(`ADCCT_UTH_L, 16'h000A);
    wr(`ADCCT_MODE, {5'h00, `ADCCT_MD_BASIC});
    wr(`ADCCT_CNT, 8'h05);
    for (m = 0; m < 8; m++) begin
      wr(`ADCCT_CTRL, {2'b00, `ADCCT_ERROR_SELECT_A_SP, m[2:0]});
      for (k = 0; k < 5; k++) begin
        wr(`ADCCT_STAT, 8'h00);
        convert(res[k], {k[2:0], 1'b0});
        expv = expect_thr(m[2:0], res[k] - 16'h0064, 16'hFFF6, 16'h000A);
        `CHK("thresholdInterrupt", expv[2], thresholdInterrupt)
        `CHK("aboveUpperFlag", expv[1], aboveUpperFlag)
        `CHK("belowLowerFlag", expv[0], belowLowerFlag)
      end
    end
    chk16(`ADCCT_ERR_L, 16'h001E);
    wr(`ADCCT_ERR_L, 8'hAA);
    chk_rd(`ADCCT_ERR_L, 8'h1E);
    chk16(`ADCCT_PREV_L, 16'h006E);
    chk_rd(`ADCCT_CNT, 8'h05);
    // Accumulator bytes and sign fill
    wr(`ADCCT_CTRL, 8'h00);
    wr(`ADCCT_ACC_U, 8'h03);
    wr16(`ADCCT_ACC_L, 16'h1234);
    chk_rd(`ADCCT_ACC_U, 8'hFF);
    chk16(`ADCCT_ACC_L, 16'h1234);
    wr(`ADCCT_ACC_U, 8'h00);
    wr16(`ADCCT_ACC_L, 16'h0000);
    wr(`ADCCT_MODE, {2'b00, 3'h2, `ADCCT_MD_ACCUM});
    convert(16'h0064, 4'h0);
    convert(16'hFF00, 4'h9);
    chk16(`ADCCT_FILTER_FIELD_L, 16'hFFD9);
    chk16(`ADCCT_ACC_L, 16'hFF64);
    chk_rd(`ADCCT_ACC_U, 8'hFF);
    wr(`ADCCT_FILTER_FIELD_L, 8'h00);
    chk_rd(`ADCCT_FILTER_FIELD_L, 8'hD9);
    // Accumulator write refused while converting
    wr(`ADCCT_CTRL, 8'h80);
    `CHK("conversionGo", 1'b1, conversionGo)
    wr(`ADCCT_ACC_L, 8'h55);
    chk_rd(`ADCCT_ACC_L, 8'h64);
    // Repeat counting in the three repeat modes
    wr(`ADCCT_CTRL, {5'h00, `ADCCT_TMD_ALWAYS});
    wr(`ADCCT_RPT, 8'h03);
    for (m = 2; m < 5; m++) begin
      wr(`ADCCT_MODE, {5'h00, m[2:0]});
      wr(`ADCCT_CNT, 8'h00);
      wr(`ADCCT_STAT, 8'h00);
      convert(16'h0010, 4'h1);
      convert(16'h0020, 4'h5);
      `CHK("thresholdInterrupt", 1'b0, thresholdInterrupt)
      chk_rd(`ADCCT_CNT, 8'h02);
      convert(16'h0030, 4'h0);
      `CHK("thresholdInterrupt", 1'b1, thresholdInterrupt)
      chk_rd(`ADCCT_CNT, 8'h00);
    end
    // Low-pass filter, filter-setpoint error, filter as previous
    wr(`ADCCT_ACC_U, 8'h00);
    wr16(`ADCCT_ACC_L, 16'h0000);
    wr(`ADCCT_RPT, 8'h02);
    wr(`ADCCT_MODE, {2'b00, 3'h1, `ADCCT_MD_LPF});
    wr(`ADCCT_CTRL, {2'b01, `ADCCT_ERROR_SELECT_A_FLT_SP, `ADCCT_TMD_NEVER});
    convert(16'h0040, 4'h0);
    convert(16'h0040, 4'h3);
    chk16(`ADCCT_FILTER_FIELD_L, 16'h0030);
    chk16(`ADCCT_PREV_L, 16'h0020);
    chk16(`ADCCT_ERR_L, 16'hFFCC);
    `CHK("belowLowerFlag", 1'b1, belowLowerFlag)
    `CHK("aboveUpperFlag", 1'b0, aboveUpperFlag)
    // Counter survives a plain reset
    wr(`ADCCT_CNT, 8'h07);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk_rd(`ADCCT_CNT, 8'h07);
    chk16(`ADCCT_UTH_L, 16'h0000);
    conclude;
  end
endmodule
